//--- rtic_top.sv
// How it works
// - Writing zero or the read-back value changes no flag or timer state.
// - Bit 0 digital shutdown flag, set by canceller event, read-only.
// - Writing 1 to bit 1 clears digital flag; reads 0.
// - Bit 2 analog shutdown flag, set by filtered pin event, read-only.
// - Writing 1 to bit 3 clears analog flag; reads 0.
// - Bit 4 pair 0 timer event flag, set on expiry, read-only.
// - Writing 1 to bit 5 clears pair 0 event; counting continues.
// - Writing 1 to bit 6 starts pair 0 timer; reads running state.
// - Writing 1 to bit 7 stops pair 0 timer and clears its event.
// - Pairs 1 and 2 repeat these controls in bits 11:8 and 15:12.
// - A timer may start only while its waveform mode frees the counter.
// - Interval equals reload value times division ratio times clock period.
// - Start loads reload value; at count 1 raise event, reload, continue.
// - New reload value takes effect only at the next reload.
// - Stop beats start and expiry, expiry beats clear, when they coincide.
// - Each timer line has its own mask; flag still sets when masked.
// - Shutdown line asserts for any unmasked shutdown flag set.
// - Digital flag sets only for low pulses at least the configured width.
// - Timer mask 1 disables its line, 0 enables it.
//
// Design decisions made here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module rtic_top
   import rtic_pkg::*;
(
   // Clock and reset
   input  wire logic        ref_clk_in,
   input  wire logic        rst_in,
   // AXI4-Lite write address
   input  wire logic [7:0]  s_axi_awaddr_in,
   input  wire logic        s_axi_awvalid_in,
   output logic             s_axi_awready_out,
   // AXI4-Lite write data
   input  wire logic [31:0] s_axi_wdata_in,
   input  wire logic [3:0]  s_axi_wstrb_in,
   input  wire logic        s_axi_wvalid_in,
   output logic             s_axi_wready_out,
   // AXI4-Lite write response
   output logic [1:0]       s_axi_bresp_out,
   output logic             s_axi_bvalid_out,
   input  wire logic        s_axi_bready_in,
   // AXI4-Lite read address
   input  wire logic [7:0]  s_axi_araddr_in,
   input  wire logic        s_axi_arvalid_in,
   output logic             s_axi_arready_out,
   // AXI4-Lite read data
   output logic [31:0]      s_axi_rdata_out,
   output logic [1:0]       s_axi_rresp_out,
   output logic             s_axi_rvalid_out,
   input  wire logic        s_axi_rready_in,
   // Shutdown inputs, both asynchronous
   input  wire logic        emergency_shutdown_pin_n_in,
   input  wire logic        analog_filter_detect_in,
   // Interrupt lines
   output logic             shutdown_interrupt_out,
   output logic [2:0]       timer_interrupt_out
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   logic                 aw_held;
   logic [7:0]           aw_addr;
   logic                 w_held;
   logic [31:0]          w_data;
   logic [3:0]           w_strb;
   logic [15:0]          noise_canceller_control;
   logic [7:0]           width;
   logic [15:0]          reload [NUM_PAIRS];
   rtic_setup_type       setup [NUM_PAIRS];
   logic                 dflag;
   logic                 aflag;
   logic [2:0]           tflag;
   logic                 an_sync1;
   logic                 an_sync2;
   logic                 an_prev;

   logic                 next_aw_held;
   logic [7:0]           next_aw_addr;
   logic                 next_w_held;
   logic [31:0]          next_w_data;
   logic [3:0]           next_w_strb;
   logic                 next_awready;
   logic                 next_wready;
   logic                 next_bvalid;
   logic [1:0]           next_bresp;
   logic                 next_arready;
   logic                 next_rvalid;
   logic [31:0]          next_rdata;
   logic [1:0]           next_rresp;
   logic [15:0]          next_noise_canceller_control;
   logic [7:0]           next_width;
   logic [15:0]          next_reload [NUM_PAIRS];
   rtic_setup_type       next_setup [NUM_PAIRS];
   logic                 next_dflag;
   logic                 next_aflag;
   logic [2:0]           next_tflag;
   logic                 next_shutdown_irq;
   logic [2:0]           next_timer_irq;

   logic                 do_wr;
   logic [31:0]          wd;
   logic                 ctl_wr;
   rtic_cmd_type         cmd [NUM_PAIRS];
   logic [2:0]           running;
   logic [2:0]           expire;
   logic                 digital_event;
   logic                 analog_event;

   // Byte-lane merge of a write into a stored word
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                         input logic [3:0] strb);
      logic [31:0] m;
      m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      return (old & ~m) | (val & m);
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      return (a == ADDR_CONTROL) || (a == ADDR_NOISE_CANCELLER_CONTROL) || (a == ADDR_WIDTH) ||
             (a == ADDR_SETUP) || ((a >= ADDR_RELOAD0) && (a < ADDR_SETUP) && (a[1:0] == 2'h0));
   endfunction

   // ----------------------------------------
   // Sub-blocks
   // ----------------------------------------
   rtic_noise_canceller u_canceller (
      .ref_clk_in        (ref_clk_in),
      .rst_in            (rst_in),
      .shutdown_pin_n_in (emergency_shutdown_pin_n_in),
      .enable_in         (noise_canceller_control[BIT_DENABLE]),
      .width_in          (width),
      .detect_out        (digital_event)
   );

   for (genvar p = 0; p < NUM_PAIRS; p++) begin : g_timer
      rtic_reload_timer u_timer (
         .ref_clk_in      (ref_clk_in),
         .rst_in          (rst_in),
         .start_in        (cmd[p].start),
         .stop_in         (cmd[p].stop),
         .reload_value_in (reload[p]),
         .div_in          (setup[p].div),
         .running_out     (running[p]),
         .expire_out      (expire[p])
      );
   end

   // Analog path edge, after two-stage synchroniser
   assign analog_event = an_sync2 && !an_prev && noise_canceller_control[BIT_AENABLE];

   // ----------------------------------------
   // Write decode and command strobes
   // ----------------------------------------
   always_comb begin
      do_wr  = aw_held && w_held && !s_axi_bvalid_out;
      wd     = merge(32'h0000_0000, w_data, w_strb);
      ctl_wr = do_wr && (aw_addr == ADDR_CONTROL);
      for (int p = 0; p < NUM_PAIRS; p++) begin
         // Only ones act; zeros and read-back bits are harmless
         cmd[p].stop  = ctl_wr && wd[BIT_TSTOP + PAIR_STEP * p];
         cmd[p].clear = ctl_wr && wd[BIT_TCLR + PAIR_STEP * p];
         cmd[p].start = ctl_wr && wd[BIT_TSTART + PAIR_STEP * p] &&
                        mode_frees_counter(setup[p].mode);
      end
   end

   // ----------------------------------------
   // Bus channels and register storage
   // ----------------------------------------
   always_comb begin
      next_aw_held = aw_held;
      next_aw_addr = aw_addr;
      next_w_held  = w_held;
      next_w_data  = w_data;
      next_w_strb  = w_strb;
      next_bvalid  = s_axi_bvalid_out;
      next_bresp   = s_axi_bresp_out;
      next_rvalid  = s_axi_rvalid_out;
      next_rdata   = s_axi_rdata_out;
      next_rresp   = s_axi_rresp_out;
      next_noise_canceller_control    = noise_canceller_control;
      next_width   = width;
      next_reload  = reload;
      next_setup   = setup;
      if (s_axi_awvalid_in && s_axi_awready_out) begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata_in;
         next_w_strb = s_axi_wstrb_in;
      end
      if (s_axi_bvalid_out && s_axi_bready_in) begin
         next_bvalid = 1'b0;
      end
      if (do_wr) begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
         if (aw_addr == ADDR_NOISE_CANCELLER_CONTROL) begin
            next_noise_canceller_control = 16'(merge({16'h0000, noise_canceller_control}, w_data, w_strb)) & NOISE_CANCELLER_CONTROL_WMASK;
         end
         if (aw_addr == ADDR_WIDTH) begin
            next_width = 8'(merge({24'h000000, width}, w_data, w_strb));
         end
         if (aw_addr == ADDR_SETUP) begin
            for (int p = 0; p < NUM_PAIRS; p++) begin
               next_setup[p] = 8'(merge({24'h000000, setup[p]}, w_data >> (8 * p),
                                        4'(w_strb >> p)));
            end
         end
         for (int p = 0; p < NUM_PAIRS; p++) begin
            if (aw_addr == ADDR_RELOAD0 + 8'(4 * p)) begin
               next_reload[p] = 16'(merge({16'h0000, reload[p]}, w_data, w_strb));
            end
         end
      end
      if (s_axi_rvalid_out && s_axi_rready_in) begin
         next_rvalid = 1'b0;
      end
      if (s_axi_arvalid_in && s_axi_arready_out) begin
         next_rvalid = 1'b1;
         next_rresp  = mapped(s_axi_araddr_in) ? RESP_OKAY : RESP_SLVERR;
         next_rdata  = 32'h0000_0000;
         case (s_axi_araddr_in)
            ADDR_CONTROL: begin
               next_rdata[BIT_DFLAG] = dflag;
               next_rdata[BIT_AFLAG] = aflag;
               for (int p = 0; p < NUM_PAIRS; p++) begin
                  next_rdata[BIT_TFLAG + PAIR_STEP * p]  = tflag[p];
                  next_rdata[BIT_TSTART + PAIR_STEP * p] = running[p];
               end
            end
            ADDR_NOISE_CANCELLER_CONTROL:  next_rdata = {16'h0000, noise_canceller_control};
            ADDR_WIDTH: next_rdata = {24'h000000, width};
            ADDR_SETUP: next_rdata = {8'h00, setup[2], setup[1], setup[0]};
            default: begin
               for (int p = 0; p < NUM_PAIRS; p++) begin
                  if (s_axi_araddr_in == ADDR_RELOAD0 + 8'(4 * p)) begin
                     next_rdata = {16'h0000, reload[p]};
                  end
               end
            end
         endcase
      end
      next_awready = !next_aw_held && !next_bvalid;
      next_wready  = !next_w_held && !next_bvalid;
      next_arready = !next_rvalid;
   end

   // ----------------------------------------
   // Flags and interrupt lines
   // ----------------------------------------
   always_comb begin
      // Event set wins over a clear in the same cycle
      next_dflag = digital_event ||
                   (dflag && !(ctl_wr && wd[BIT_DCLR]));
      next_aflag = analog_event ||
                   (aflag && !(ctl_wr && wd[BIT_ACLR]));
      for (int p = 0; p < NUM_PAIRS; p++) begin
         // Stop outranks everything, the late expiry included
         next_tflag[p] = !cmd[p].stop &&
                         (expire[p] || (tflag[p] && !cmd[p].clear));
         next_timer_irq[p] = next_tflag[p] && !next_noise_canceller_control[BIT_TMASK0 + p];
      end
      next_shutdown_irq = (next_dflag && !next_noise_canceller_control[BIT_DMASK]) ||
                          (next_aflag && !next_noise_canceller_control[BIT_AMASK]);
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         aw_held                <= 1'b0;
         aw_addr                <= 8'h00;
         w_held                 <= 1'b0;
         w_data                 <= 32'h0000_0000;
         w_strb                 <= 4'h0;
         s_axi_awready_out      <= 1'b0;
         s_axi_wready_out       <= 1'b0;
         s_axi_bvalid_out       <= 1'b0;
         s_axi_bresp_out        <= RESP_OKAY;
         s_axi_arready_out      <= 1'b0;
         s_axi_rvalid_out       <= 1'b0;
         s_axi_rdata_out        <= 32'h0000_0000;
         s_axi_rresp_out        <= RESP_OKAY;
         noise_canceller_control                   <= RESET_NOISE_CANCELLER_CONTROL;
         width                  <= RESET_WIDTH;
         reload                 <= '{default: RESET_RELOAD};
         setup                  <= '{default: RESET_SETUP};
         dflag                  <= 1'b0;
         aflag                  <= 1'b0;
         tflag                  <= 3'h0;
         an_sync1               <= 1'b0;
         an_sync2               <= 1'b0;
         an_prev                <= 1'b0;
         shutdown_interrupt_out <= 1'b0;
         timer_interrupt_out    <= 3'h0;
      end else begin
         aw_held                <= next_aw_held;
         aw_addr                <= next_aw_addr;
         w_held                 <= next_w_held;
         w_data                 <= next_w_data;
         w_strb                 <= next_w_strb;
         s_axi_awready_out      <= next_awready;
         s_axi_wready_out       <= next_wready;
         s_axi_bvalid_out       <= next_bvalid;
         s_axi_bresp_out        <= next_bresp;
         s_axi_arready_out      <= next_arready;
         s_axi_rvalid_out       <= next_rvalid;
         s_axi_rdata_out        <= next_rdata;
         s_axi_rresp_out        <= next_rresp;
         noise_canceller_control                   <= next_noise_canceller_control;
         width                  <= next_width;
         reload                 <= next_reload;
         setup                  <= next_setup;
         dflag                  <= next_dflag;
         aflag                  <= next_aflag;
         tflag                  <= next_tflag;
         an_sync1               <= analog_filter_detect_in;
         an_sync2               <= an_sync1;
         an_prev                <= an_sync2;
         shutdown_interrupt_out <= next_shutdown_irq;
         timer_interrupt_out    <= next_timer_irq;
      end
   end
endmodule // rtic_top
`default_nettype wire

//--- rtic_pkg.sv
package rtic_pkg;
   // ----------------------------------------
   // Register map, byte addresses
   // ----------------------------------------
   localparam logic [7:0] ADDR_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_NOISE_CANCELLER_CONTROL    = 8'h04;
   localparam logic [7:0] ADDR_WIDTH   = 8'h08;
   localparam logic [7:0] ADDR_RELOAD0 = 8'h0c;
   localparam logic [7:0] ADDR_SETUP   = 8'h18;
   localparam int         NUM_PAIRS    = 3;

   // ----------------------------------------
   // Control register field positions
   // ----------------------------------------
   localparam int BIT_DFLAG  = 0;
   localparam int BIT_DCLR   = 1;
   localparam int BIT_AFLAG  = 2;
   localparam int BIT_ACLR   = 3;
   localparam int BIT_TFLAG  = 4;
   localparam int BIT_TCLR   = 5;
   localparam int BIT_TSTART = 6;
   localparam int BIT_TSTOP  = 7;
   localparam int PAIR_STEP  = 4;

   // ----------------------------------------
   // Noise canceller control field positions
   // ----------------------------------------
   localparam int BIT_DENABLE = 4;
   localparam int BIT_AENABLE = 5;
   localparam int BIT_DMASK   = 8;
   localparam int BIT_AMASK   = 9;
   localparam int BIT_TMASK0  = 12;
   localparam logic [15:0] NOISE_CANCELLER_CONTROL_WMASK = 16'h733f;

   // ----------------------------------------
   // Reset values and responses
   // ----------------------------------------
   localparam logic [15:0] RESET_NOISE_CANCELLER_CONTROL   = 16'h0000;
   localparam logic [7:0]  RESET_WIDTH  = 8'h01;
   localparam logic [15:0] RESET_RELOAD = 16'h0000;
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;

   // Per-pair setup: waveform mode and clock division
   typedef struct packed {
      logic [1:0] spare;
      logic [2:0] mode;
      logic [2:0] div;
   } rtic_setup_type;

   localparam rtic_setup_type RESET_SETUP = '{spare: 2'h0, mode: 3'h0, div: 3'h0};

   // Software commands to one reload timer
   typedef struct packed {
      logic stop;
      logic clear;
      logic start;
   } rtic_cmd_type;

   // Modes in which the pulse counter is free for timer use
   function automatic logic mode_frees_counter(input logic [2:0] mode);
      return (mode == 3'h0) || (mode == 3'h1) || (mode == 3'h2) ||
             (mode == 3'h4) || (mode == 3'h7);
   endfunction
endpackage

//--- rtic_reload_timer.sv
`timescale 1ns/1ps
`default_nettype none
module rtic_reload_timer
   import rtic_pkg::*;
(
   // Clock and reset
   input  wire logic        ref_clk_in,
   input  wire logic        rst_in,
   // Control
   input  wire logic        start_in,
   input  wire logic        stop_in,
   input  wire logic [15:0] reload_value_in,
   input  wire logic [2:0]  div_in,
   // Status
   output logic             running_out,
   output logic             expire_out
);
   logic [15:0] count;
   logic [7:0]  presc;
   logic [15:0] next_count;
   logic [7:0]  next_presc;
   logic        next_running;
   logic        next_expire;
   logic [7:0]  ratio_m1;

   always_comb begin
      ratio_m1     = (8'h01 << div_in) - 8'h01;
      next_count   = count;
      next_presc   = presc;
      next_running = running_out;
      next_expire  = 1'b0;
      if (stop_in) begin
         next_running = 1'b0;
         next_presc   = 8'h00;
      end else if (start_in && !running_out) begin
         next_running = 1'b1;
         next_count   = reload_value_in;
         next_presc   = 8'h00;
      end else if (running_out) begin
         if (presc == ratio_m1) begin
            next_presc = 8'h00;
            if (count <= 16'h0001) begin
               next_expire = 1'b1;
               next_count  = reload_value_in;
            end else begin
               next_count = count - 16'h0001;
            end
         end else begin
            next_presc = presc + 8'h01;
         end
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         count       <= 16'h0000;
         presc       <= 8'h00;
         running_out <= 1'b0;
         expire_out  <= 1'b0;
      end else begin
         count       <= next_count;
         presc       <= next_presc;
         running_out <= next_running;
         expire_out  <= next_expire;
      end
   end
endmodule // rtic_reload_timer
`default_nettype wire

//--- rtic_noise_canceller.sv
`timescale 1ns/1ps
`default_nettype none
module rtic_noise_canceller
   import rtic_pkg::*;
(
   // Clock and reset
   input  wire logic       ref_clk_in,
   input  wire logic       rst_in,
   // Pin and settings
   input  wire logic       shutdown_pin_n_in,
   input  wire logic       enable_in,
   input  wire logic [7:0] width_in,
   // Result
   output logic            detect_out
);
   logic       sync1;
   logic       sync2;
   logic [7:0] low_cnt;
   logic [7:0] next_low_cnt;
   logic       next_detect;
   logic [7:0] need;

   always_comb begin
      need         = (width_in == 8'h00) ? 8'h01 : width_in;
      next_low_cnt = 8'h00;
      next_detect  = 1'b0;
      if (enable_in && !sync2) begin
         next_low_cnt = (low_cnt == 8'hff) ? low_cnt : low_cnt + 8'h01;
         next_detect  = (low_cnt + 8'h01 == need);
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         sync1      <= 1'b1;
         sync2      <= 1'b1;
         low_cnt    <= 8'h00;
         detect_out <= 1'b0;
      end else begin
         sync1      <= shutdown_pin_n_in;
         sync2      <= sync1;
         low_cnt    <= next_low_cnt;
         detect_out <= next_detect;
      end
   end
endmodule // rtic_noise_canceller
`default_nettype wire

//--- rtic_properties.sv
`timescale 1ns/1ps
`default_nettype none
module rtic_properties
   import rtic_pkg::*;
(
   // Clock and reset
   input wire logic        ref_clk_in,
   input wire logic        rst_in,
   // Register bus
   input wire logic        s_axi_awvalid_in,
   input wire logic        s_axi_awready_out,
   input wire logic        s_axi_wvalid_in,
   input wire logic        s_axi_wready_out,
   input wire logic        s_axi_bvalid_out,
   input wire logic        s_axi_bready_in,
   input wire logic        s_axi_arvalid_in,
   input wire logic        s_axi_arready_out,
   input wire logic [31:0] s_axi_rdata_out,
   input wire logic [1:0]  s_axi_rresp_out,
   input wire logic        s_axi_rvalid_out,
   input wire logic        s_axi_rready_in,
   // Interrupt lines
   input wire logic        shutdown_interrupt_out,
   input wire logic [2:0]  timer_interrupt_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   // ------------------
   // Handshake steps
   // ------------------
   sequence wr_taken;
      s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
   endsequence
   sequence rd_taken;
      s_axi_arvalid_in && s_axi_arready_out;
   endsequence
   sequence b_taken;
      s_axi_bvalid_out && s_axi_bready_in;
   endsequence
   a_write_answer: assert property (wr_taken |-> ##2 s_axi_bvalid_out)
      else $error("write response not on time");
   a_read_answer: assert property (rd_taken |=> s_axi_rvalid_out && !s_axi_arready_out)
      else $error("read answer not on time");
   a_write_refused: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
      else $error("write accepted during response");
   a_read_refused: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
      else $error("read accepted during answer");
   a_read_stands: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
      s_axi_rvalid_out && $stable(s_axi_rdata_out) && $stable(s_axi_rresp_out))
      else $error("read answer changed before taken");
   a_unmapped_zero: assert property (s_axi_rvalid_out && s_axi_rresp_out == RESP_SLVERR |->
      s_axi_rdata_out == 32'h0)
      else $error("refused read returned data");
   a_ready_back: assert property (b_taken |-> ##[1:2] s_axi_awready_out)
      else $error("write channel not ready again");
   a_reset_quiet: assert property ($fell(rst_in) |-> !s_axi_awready_out && !s_axi_arready_out &&
      !shutdown_interrupt_out && timer_interrupt_out == 3'h0)
      else $error("outputs active after reset");
endmodule // rtic_properties

bind rtic_top rtic_properties u_props (.ref_clk_in, .rst_in, .s_axi_awvalid_in, .s_axi_awready_out,
   .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_arvalid_in,
   .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in,
   .shutdown_interrupt_out, .timer_interrupt_out);
`default_nettype wire

//--- rtic_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin fail_count++; $display("CHECK FAILED %s exp %0h got %0h", n, e, s); end end
module testbench
   import rtic_pkg::*;
;
   logic        clk = 1'b0, rst = 1'b1, pin_n = 1'b1, ana = 1'b0;
   logic [7:0]  awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata, rv, d1;
   logic [3:0]  wstrb = 4'hf;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic        awready, wready, bvalid, arready, rvalid, sdi;
   logic [1:0]  bresp, rresp, rs;
   logic [2:0]  tio;
   logic [15:0] lf = 16'h0057;
   int          fail_count = 0, comparisons = 0, p, m, rl, dv;
   time         t0;

   rtic_top dut (.ref_clk_in(clk), .rst_in(rst), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
      .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
      .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
      .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
      .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
      .emergency_shutdown_pin_n_in(pin_n), .analog_filter_detect_in(ana),
      .shutdown_interrupt_out(sdi), .timer_interrupt_out(tio));

   always #5 clk = ~clk;

   function automatic logic [15:0] nx(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   // Modes that leave the pulse counter free
   function automatic logic frees(input int md);
      return md inside {0, 1, 2, 4, 7};
   endfunction

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      rs = bresp;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
      rv = rdata;
      rs = rresp;
   endtask

   task automatic pulse(input int w);
      @(posedge clk);
      pin_n <= 1'b0;
      repeat (w) @(posedge clk);
      pin_n <= 1'b1;
      repeat (10) @(posedge clk);
   endtask

   task automatic summarize();
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial begin
      repeat (30000) @(posedge clk);
      fail_count++;
      summarize();
   end

   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      rd(ADDR_CONTROL);
      `CHK("control reset", 32'h0, rv)
      wr(8'h40, 32'hffff);
      `CHK("write refused", RESP_SLVERR, rs)
      rd(8'h40);
      `CHK("unmapped", {RESP_SLVERR, 32'h0}, {rs, rv})
      for (m = 0; m < 8; m++) begin
         wr(ADDR_SETUP, 32'(m) << 11);
         wr(ADDR_CONTROL, 32'h400);
         rd(ADDR_CONTROL);
         `CHK("mode gate", frees(m), rv[10])
         wr(ADDR_CONTROL, 32'h800);
      end
      for (int i = 0; i < 4; i++) begin
         p = i % 3;
         lf = nx(lf);
         rl = 6 + lf[2:0];
         dv = lf[4:3];
         wr(ADDR_RELOAD0 + 8'(4 * p), rl);
         wr(ADDR_SETUP, dv << (8 * p));
         wr(ADDR_CONTROL, 32'h40 << (4 * p));
         rd(ADDR_CONTROL);
         `CHK("running", 1'b1, rv[4 * p + 6])
         wait (tio[p] === 1'b1);
         wr(ADDR_CONTROL, 32'h20 << (4 * p));
         `CHK("line cleared", 1'b0, tio[p])
         wait (tio[p] === 1'b1);
         t0 = $time;
         wr(ADDR_CONTROL, 32'h20 << (4 * p));
         wait (tio[p] === 1'b1);
         `CHK("interval", rl << dv, int'(($time - t0) / 10))
         wr(ADDR_NOISE_CANCELLER_CONTROL, 32'h1000 << p);
         wr(ADDR_CONTROL, 32'h20 << (4 * p));
         repeat ((rl << dv) + 4) @(posedge clk);
         `CHK("masked line", 1'b0, tio[p])
         rd(ADDR_CONTROL);
         `CHK("masked flag", 4'h5, rv[4 * p + 4 +: 4])
         d1 = rv;
         wr(ADDR_CONTROL, 32'h0);
         wr(ADDR_CONTROL, d1);
         rd(ADDR_CONTROL);
         `CHK("write back", 32'h50 << (4 * p), rv)
         wr(ADDR_CONTROL, 32'he0 << (4 * p));
         rd(ADDR_CONTROL);
         `CHK("stop first", 4'h0, rv[4 * p + 4 +: 4])
         wr(ADDR_NOISE_CANCELLER_CONTROL, 32'h0);
      end
      wr(ADDR_WIDTH, 32'h3);
      wr(ADDR_NOISE_CANCELLER_CONTROL, 32'h30);
      pulse(2);
      rd(ADDR_CONTROL);
      `CHK("short pulse", 1'b0, rv[0])
      pulse(8);
      `CHK("shutdown line", 1'b1, sdi)
      wr(ADDR_CONTROL, 32'h1);
      rd(ADDR_CONTROL);
      `CHK("digital flag", 4'h1, rv[3:0])
      wr(ADDR_CONTROL, 32'h2);
      `CHK("digital clear", 1'b0, sdi)
      ana <= 1'b1;
      wr(ADDR_NOISE_CANCELLER_CONTROL, 32'h230);
      rd(ADDR_CONTROL);
      `CHK("analog flag", 4'h4, rv[3:0])
      `CHK("analog masked", 1'b0, sdi)
      wr(ADDR_CONTROL, 32'h8);
      rd(ADDR_CONTROL);
      `CHK("analog clear", 4'h0, rv[3:0])
      ana <= 1'b0;
      summarize();
   end
endmodule // testbench
`default_nettype wire
